// ### seq_consts.svh
// Constants for the slot power sequencer: offsets, fields, reset values, timing
//
// Overview of operation
// - Outputs ten to twelve take drive style from a 2-bit polarity/drive field
// - Outputs float until reset releases; outputs one to nine then drive low, ten to twelve stay released
// - Enable outputs switch on in ascending slot order, slot 0 to 11
// - All outputs of one slot switch on in the same cycle
// - Each slot has its own sequence delay from 20us to 2.4s
// - Reverse power-down turns slots off descending, starting at slot 11
// - One bit picks simultaneous or reverse-order power-down
// - Monitors may be assigned to slots 1 to 12, never slot 0
// - A slot's monitors must pass undervoltage within the fault delay, else fault
// - Sequencing undervoltage fault ignores fault enables and runs up and down
// - Outputs of slots 1 to 11 assert once that slot's delay expires
// - Slot 0 checks no monitor and waits for software enable 0 and enable high
// - Slot 0 outputs assert at slot start, before its delay
// - Slot 12 drives no outputs, checks monitors, then enters power-on
// - Power-up completes when slot 12 monitors pass and its delay expires
// - With no slot 12 monitor, completion follows the slot 12 delay alone
// - Enable low or software bit 1 starts power-down and asserts reset
// - Reverse power-down waits each slot's delay before the next lower slot
// - Output slot code 0 unassigned, 1 to 12 give slots 0 to 11
// - Monitor slot code 0 unassigned, 1 to 12 give slots 1 to 12
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// Register offsets
`define A_DRV   8'h22 // upper_output_drive_config
`define A_SWEN  8'h4D
`define A_PUF   8'h4E
`define A_REV   8'h54
`define A_MSL   8'h56
`define A_OSL   8'h5E
`define A_SDL   8'h70
`define A_STAT  8'h80

// Field positions and reset values
`define B_SWEN  0
`define B_REV   4
`define RST_DRV 6'h00

// Slot limits
`define SLOT_TOP 4'd11
`define SLOT_END 4'd12

// Timing: clock period, delay tick, tick counts
`define CLK_NS   25
`define TICK_NS  20000
`define TICK_CYC ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define DLY_T0   17'd1
`define DLY_T1   17'd938
`define DLY_T2   17'd1875
`define DLY_T3   17'd3750
`define DLY_T4   17'd7500
`define DLY_T5   17'd15000
`define DLY_T6   17'd30000
`define DLY_T7   17'd120000
`define PUF_T0   14'd1875
`define PUF_T1   14'd3750
`define PUF_T2   14'd7500
`define PUF_T3   14'd15000

`endif

// ### seq_pkg.sv
// Types shared by the slot power sequencer
package seq_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_UP,
        S_ON,
        S_DOWN,
        S_FAULT
    } seq_state_e;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Whole state of the sequencer
    typedef struct packed {
        seq_state_e  st;
        logic [3:0]  cur;
        logic        chk;
        logic [15:0] pre;
        logic [16:0] dly;
        logic [13:0] flt;
        logic [11:0] asg;
        logic [5:0]  drv;
        logic [47:0] osl;
        logic [47:0] msl;
        logic [38:0] sdl;
        logic        sw;
        logic        rev;
        logic [1:0]  pufd;
        logic        fault;
        logic        pgood;
        logic        rst_act;
        logic [11:0] pin;
        logic [11:0] oe;
        logic [7:0]  rdata;
    } seq_st_s;

endpackage

// ### slot_power_sequencer.sv
// Slot-ordered power-supply sequencer with register port
`timescale 1ns/1ps
`include "seq_consts.svh"

module slot_power_sequencer
    import seq_pkg::*;
#(
    parameter int TICK_CYC = `TICK_CYC
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire reg_req_s    reg_req_i,
    output logic [7:0]       reg_rdata_o,
    // Enable input and monitor comparator results
    input  wire logic        ext_enable_i,
    input  wire logic [11:0] voltage_monitor_input_i,
    // Sequencing outputs; bits 9..11 are outputs ten to twelve
    output logic [11:0]      seq_enable_output_o,
    output logic [11:0]      seq_enable_output_oe_o,
    // Status
    output logic             seq_fault_o,
    output logic             power_good_o,
    output logic             reset_active_o
);

    seq_st_s     st_q;
    seq_st_s     st_d;
    logic        tick;
    logic        dreq;
    logic        ok_cur;
    logic        bad;
    logic [3:0]  lim;

    // Outputs assigned to slot s
    function automatic logic [11:0] omask(
        input logic [47:0] osl,
        input logic [3:0]  s
    );
        logic [11:0] m;
        m = '0;
        for (int i = 0; i < 12; i++) begin
            m[i] = (osl[4*i+:4] == s + 4'd1);
        end
        return m;
    endfunction

    // Outputs assigned to slot s or above
    function automatic logic [11:0] omask_ge(
        input logic [47:0] osl,
        input logic [3:0]  s
    );
        logic [11:0] m;
        logic [3:0]  c;
        m = '0;
        for (int i = 0; i < 12; i++) begin
            c = osl[4*i+:4];
            m[i] = (c != 4'd0) && (c <= 4'd12) && (c > s);
        end
        return m;
    endfunction

    // Monitors assigned to slot s
    function automatic logic [11:0] mmask(
        input logic [47:0] msl,
        input logic [3:0]  s
    );
        logic [11:0] m;
        m = '0;
        for (int i = 0; i < 12; i++) begin
            m[i] = (s != 4'd0) && (msl[4*i+:4] == s);
        end
        return m;
    endfunction

    // Monitors assigned to slots 1 up to lim
    function automatic logic [11:0] mupto(
        input logic [47:0] msl,
        input logic [3:0]  lim
    );
        logic [11:0] m;
        logic [3:0]  c;
        m = '0;
        for (int i = 0; i < 12; i++) begin
            c = msl[4*i+:4];
            m[i] = (c != 4'd0) && (c <= lim) && (c <= 4'd12);
        end
        return m;
    endfunction

    // Sequence delay of a slot in ticks
    function automatic logic [16:0] dly_ticks(
        input logic [38:0] sdl,
        input logic [3:0]  s
    );
        logic [16:0] t;
        t = `DLY_T0;
        unique case (sdl[3*s+:3])
            3'h0: t = `DLY_T0;
            3'h1: t = `DLY_T1;
            3'h2: t = `DLY_T2;
            3'h3: t = `DLY_T3;
            3'h4: t = `DLY_T4;
            3'h5: t = `DLY_T5;
            3'h6: t = `DLY_T6;
            3'h7: t = `DLY_T7;
        endcase
        return t;
    endfunction

    // Power-up fault delay in ticks
    function automatic logic [13:0] puf_ticks(
        input logic [1:0] c
    );
        logic [13:0] t;
        t = `PUF_T0;
        unique case (c)
            2'h0: t = `PUF_T0;
            2'h1: t = `PUF_T1;
            2'h2: t = `PUF_T2;
            2'h3: t = `PUF_T3;
        endcase
        return t;
    endfunction

    // Tick, power-down request and monitor checks
    assign tick = (st_q.pre == 16'(TICK_CYC - 1));
    assign dreq = st_q.sw || !ext_enable_i;
    assign ok_cur = &(voltage_monitor_input_i | ~mmask(st_q.msl, st_q.cur));
    assign lim = (st_q.st == S_UP) ? (st_q.chk ? st_q.cur - 4'd1 : st_q.cur) :
                 (st_q.st == S_DOWN) ? st_q.cur :
                 (st_q.st == S_ON) ? `SLOT_END : 4'd0;
    assign bad = |(~voltage_monitor_input_i & mupto(st_q.msl, lim));

    // Next-state logic
    always_comb begin
        logic [1:0] mode;
        logic       lvl;
        mode = 2'b11;
        lvl = 1'b0;
        st_d = st_q;
        st_d.rdata = 8'h00;
        st_d.pre = tick ? 16'h0000 : st_q.pre + 16'h0001;

        // Register writes
        if (reg_req_i.wr) begin
            if (reg_req_i.addr == `A_DRV) st_d.drv = reg_req_i.wdata[5:0];
            if (reg_req_i.addr == `A_SWEN) st_d.sw = reg_req_i.wdata[`B_SWEN];
            if (reg_req_i.addr == `A_PUF) st_d.pufd = reg_req_i.wdata[1:0];
            if (reg_req_i.addr == `A_REV) st_d.rev = reg_req_i.wdata[`B_REV];
            for (int k = 0; k < 6; k++) begin
                if (reg_req_i.addr == `A_MSL + 8'(k)) st_d.msl[8*k+:8] = reg_req_i.wdata;
                if (reg_req_i.addr == `A_OSL + 8'(k)) st_d.osl[8*k+:8] = reg_req_i.wdata;
            end
            for (int k = 0; k < 13; k++) begin
                if (reg_req_i.addr == `A_SDL + 8'(k)) st_d.sdl[3*k+:3] = reg_req_i.wdata[2:0];
            end
        end

        // Register reads, unmapped ones return zero
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == `A_DRV) st_d.rdata = {2'b00, st_q.drv};
            if (reg_req_i.addr == `A_SWEN) st_d.rdata = {7'h00, st_q.sw};
            if (reg_req_i.addr == `A_PUF) st_d.rdata = {6'h00, st_q.pufd};
            if (reg_req_i.addr == `A_REV) st_d.rdata = {3'h0, st_q.rev, 4'h0};
            if (reg_req_i.addr == `A_STAT) begin
                st_d.rdata = {st_q.cur, 1'b0, st_q.rst_act, st_q.pgood, st_q.fault};
            end
            for (int k = 0; k < 6; k++) begin
                if (reg_req_i.addr == `A_MSL + 8'(k)) st_d.rdata = st_q.msl[8*k+:8];
                if (reg_req_i.addr == `A_OSL + 8'(k)) st_d.rdata = st_q.osl[8*k+:8];
            end
            for (int k = 0; k < 13; k++) begin
                if (reg_req_i.addr == `A_SDL + 8'(k)) st_d.rdata = {5'h00, st_q.sdl[3*k+:3]};
            end
        end

        // Sequencer
        if (dreq && (st_q.st == S_UP || st_q.st == S_ON)) begin
            st_d.pgood = 1'b0;
            st_d.rst_act = 1'b1;
            if (st_q.rev) begin
                st_d.st = S_DOWN;
                st_d.cur = `SLOT_TOP;
                st_d.asg = st_q.asg & ~omask_ge(st_q.osl, `SLOT_TOP);
                st_d.dly = dly_ticks(st_q.sdl, `SLOT_TOP);
                st_d.pre = 16'h0000;
            end else begin
                st_d.st = S_IDLE;
                st_d.asg = '0;
            end
        end else begin
            unique case (st_q.st)
                S_IDLE: begin
                    if (!st_q.sw && ext_enable_i) begin
                        st_d.st = S_UP;
                        st_d.cur = 4'd0;
                        st_d.chk = 1'b0;
                        st_d.fault = 1'b0;
                        st_d.asg = omask(st_q.osl, 4'd0);
                        st_d.dly = dly_ticks(st_q.sdl, 4'd0);
                        st_d.pre = 16'h0000;
                    end
                end
                S_UP: begin
                    if (bad) begin
                        st_d.st = S_FAULT;
                        st_d.fault = 1'b1;
                    end else if (st_q.chk) begin
                        if (ok_cur) begin
                            st_d.chk = 1'b0;
                            st_d.dly = dly_ticks(st_q.sdl, st_q.cur);
                            st_d.pre = 16'h0000;
                        end else if (st_q.flt == 14'd0) begin
                            st_d.st = S_FAULT;
                            st_d.fault = 1'b1;
                        end else if (tick) begin
                            st_d.flt = st_q.flt - 14'd1;
                        end
                    end else if (st_q.dly != 17'd0) begin
                        if (tick) st_d.dly = st_q.dly - 17'd1;
                    end else if (st_q.cur == `SLOT_END) begin
                        st_d.st = S_ON;
                        st_d.pgood = 1'b1;
                        st_d.rst_act = 1'b0;
                    end else begin
                        st_d.asg = st_q.asg | omask(st_q.osl, st_q.cur);
                        st_d.cur = st_q.cur + 4'd1;
                        st_d.chk = 1'b1;
                        st_d.flt = puf_ticks(st_q.pufd);
                        st_d.pre = 16'h0000;
                    end
                end
                S_ON: begin
                    if (bad) begin
                        st_d.st = S_FAULT;
                        st_d.fault = 1'b1;
                    end
                end
                S_DOWN: begin
                    if (bad) begin
                        st_d.st = S_FAULT;
                        st_d.fault = 1'b1;
                    end else if (st_q.dly != 17'd0) begin
                        if (tick) st_d.dly = st_q.dly - 17'd1;
                    end else if (st_q.cur == 4'd0) begin
                        st_d.st = S_IDLE;
                    end else begin
                        st_d.cur = st_q.cur - 4'd1;
                        st_d.asg = st_q.asg & ~omask_ge(st_q.osl, st_q.cur - 4'd1);
                        st_d.dly = dly_ticks(st_q.sdl, st_q.cur - 4'd1);
                        st_d.pre = 16'h0000;
                    end
                end
                S_FAULT: begin
                    st_d.pgood = 1'b0;
                    st_d.rst_act = 1'b1;
                    if (dreq) begin
                        st_d.st = S_IDLE;
                        st_d.asg = '0;
                    end
                end
                default: st_d.st = S_IDLE;
            endcase
        end

        // Pin drive from polarity and drive style
        for (int i = 0; i < 12; i++) begin
            mode = (i < 9) ? 2'b11 : st_d.drv[2*(i-9)+:2];
            lvl = mode[0] ? st_d.asg[i] : ~st_d.asg[i];
            if (mode[1]) begin
                st_d.pin[i] = lvl;
                st_d.oe[i] = 1'b1;
            end else begin
                st_d.pin[i] = 1'b0;
                st_d.oe[i] = ~lvl;
            end
        end
    end

    // State register; reset floats every output
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_q <= '0;
            st_q.drv <= `RST_DRV;
            st_q.rst_act <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_o = st_q.rdata;
    assign seq_enable_output_o = st_q.pin;
    assign seq_enable_output_oe_o = st_q.oe;
    assign seq_fault_o = st_q.fault;
    assign power_good_o = st_q.pgood;
    assign reset_active_o = st_q.rst_act;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    drive_mode_a: assert property (
        st_q.drv[1:0] == 2'b00 && $past(st_q.drv[1:0]) == 2'b00 |->
        seq_enable_output_oe_o[9] == st_q.asg[9] && !seq_enable_output_o[9])
        else $error("output ten open-drain active-low drive wrong");

    float_reset_a: assert property (
        $fell(reset_i) |-> seq_enable_output_oe_o == 12'h000
        ##1 seq_enable_output_oe_o[8:0] == 9'h1FF)
        else $error("outputs not floating then driven around reset");

    slot_step_a: assert property (
        st_q.st == S_UP && $past(st_q.st) == S_UP && st_q.asg != $past(st_q.asg) |->
        st_q.asg == ($past(st_q.asg) | omask(st_q.osl, $past(st_q.cur))))
        else $error("outputs of one slot did not switch together");

    slot_zero_a: assert property (
        st_q.st == S_IDLE ##1 st_q.st == S_UP |->
        st_q.cur == 4'd0 && st_q.asg == omask(st_q.osl, 4'd0))
        else $error("slot zero outputs not asserted at start");

    hold_delay_a: assert property (
        st_q.st == S_UP && !st_q.chk && st_q.dly != 17'd0 && !dreq |=>
        st_q.asg == $past(st_q.asg))
        else $error("outputs changed before delay expired");

    uv_fault_a: assert property (
        st_q.st == S_UP && st_q.chk && st_q.flt == 14'd0 && !ok_cur && !dreq |=>
        st_q.st == S_FAULT && seq_fault_o)
        else $error("undervoltage timeout did not fault");

    rev_start_a: assert property (
        st_q.st != S_DOWN ##1 st_q.st == S_DOWN |-> st_q.cur == 4'd11)
        else $error("reverse power-down not begun at slot eleven");

    simul_off_a: assert property (
        (st_q.st == S_UP || st_q.st == S_ON) && dreq && !st_q.rev |=>
        st_q.asg == 12'h000 && st_q.st == S_IDLE)
        else $error("simultaneous power-down left outputs on");

    reset_out_a: assert property (
        (st_q.st == S_UP || st_q.st == S_ON) && dreq |=> reset_active_o && !power_good_o)
        else $error("reset not asserted at power-down");

    power_done_a: assert property (
        $rose(power_good_o) |->
        $past(st_q.cur) == 4'd12 && $past(st_q.dly) == 17'd0 && $past(ok_cur))
        else $error("power-on declared early");

endmodule // slot_power_sequencer

// ### supply_model.sv
// Model of the external supplies fed by the sequencing outputs
`timescale 1ns/1ps

module supply_model #(
    parameter int LAG = 12
) (
    // Clock
    input  wire logic        core_clk_i,
    // Enable pins and rails forced to fail
    input  wire logic [11:0] pin_i,
    input  wire logic [11:0] oe_i,
    input  wire logic [11:0] fail_i,
    // Supply enables seen and comparator results
    output logic [11:0]      supply_on_o,
    output logic [11:0]      rail_ok_o
);
    int ramp [12];

    // Released pins are pulled up; enables are used active high
    always_comb begin
        for (int k = 0; k < 12; k++) begin
            supply_on_o[k] = oe_i[k] ? pin_i[k] : 1'b1;
        end
    end

    // Rail passes LAG cycles after enable, drops at once; no tracking or sense path
    always_ff @(posedge core_clk_i) begin
        for (int k = 0; k < 12; k++) begin
            ramp[k] <= !supply_on_o[k] ? 0 : (ramp[k] < LAG ? ramp[k] + 1 : LAG);
            rail_ok_o[k] <= supply_on_o[k] && ramp[k] >= LAG && !fail_i[k];
        end
    end
endmodule // supply_model

// ### tb_top.sv
// Self-checking testbench for the slot power sequencer
`timescale 1ns/1ps
`include "seq_consts.svh"

module tb_top;
    import seq_pkg::*;

    localparam int TCK = 2;
    localparam int LAG = 12;
    localparam int D1  = 938 * TCK;
    localparam int PUF = 1875 * TCK;

    logic        core_clk_i;
    logic        reset_i;
    reg_req_s    reg_req;
    logic [7:0]  reg_rdata;
    logic        ext_en;
    logic [11:0] rail_ok, pin, oe, on, fail;
    logic        fault, pgood, rst_act;
    int          err_total, checks, n, t0, t_pg, t_flt;
    int          cyc = 0;
    int          t_on [12];
    int          t_off [12];

    slot_power_sequencer #(.TICK_CYC(TCK)) u_slot_power_sequencer (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_req_i(reg_req), .reg_rdata_o(reg_rdata),
        .ext_enable_i(ext_en), .voltage_monitor_input_i(rail_ok), .seq_enable_output_o(pin),
        .seq_enable_output_oe_o(oe), .seq_fault_o(fault), .power_good_o(pgood), .reset_active_o(rst_act));

    supply_model #(.LAG(LAG)) u_supply_model (
        .core_clk_i(core_clk_i), .pin_i(pin), .oe_i(oe), .fail_i(fail), .supply_on_o(on), .rail_ok_o(rail_ok));

    // Clock
    initial core_clk_i = 1'b0;
    always #12.5 core_clk_i = ~core_clk_i;

    // Cycle count and first edge of each supply since arming
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        for (int k = 0; k < 12; k++) begin
            if (on[k] && t_on[k] < 0) t_on[k] <= cyc;
            if (!on[k] && t_off[k] < 0) t_off[k] <= cyc;
        end
        if (pgood && t_pg < 0) t_pg <= cyc;
        if (fault && t_flt < 0) t_flt <= cyc;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_i);
        reg_req <= '0;
    endtask

    task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge core_clk_i);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_i);
        reg_req <= '0;
        #1;
        chk(name, reg_rdata & m, exp);
    endtask

    // Clear edge records away from the recording edge
    task automatic arm;
        @(negedge core_clk_i);
        for (int k = 0; k < 12; k++) begin
            t_on[k] = -1;
            t_off[k] = -1;
        end
        t_pg = -1;
        t_flt = -1;
        t0 = cyc;
    endtask

    task automatic wait_pg;
        for (n = 0; n < 6000 && pgood !== 1'b1; n++) @(posedge core_clk_i);
        #1;
        chk("power good", pgood, 1'b1);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(25 * 20000);
        err_total++;
        $display("FAIL watchdog expected end seen timeout");
        print_verdict();
    end

    initial begin
        reset_i = 1'b1;
        reg_req = '0;
        ext_en = 1'b0;
        fail = '0;
        err_total = 0;
        checks = 0;
        repeat (5) @(posedge core_clk_i);
        #1;
        chk("oe in reset", oe, 12'h000);
        repeat (5) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("oe after reset", oe, 12'h1FF);
        chk("pin after reset", pin, 12'h000);
        rdc("status", `A_STAT, 8'h07, 8'h04);
        rdc("drive cfg", `A_DRV, 8'hFF, 8'h00);
        wr(`A_DRV, 8'hFF);
        rdc("drive reserved", `A_DRV, 8'hFF, 8'h3F);
        wr(8'h23, 8'h5A);
        rdc("unmapped", 8'h23, 8'hFF, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(`A_DRV, {2'b00, c[1:0], c[1:0], c[1:0]});
            @(posedge core_clk_i);
            #1;
            chk("drive oe", oe[11:9], (c == 0) ? 3'b000 : 3'b111);
            chk("drive pin", pin[11:9] & oe[11:9], (c == 2) ? 3'b111 : 3'b000);
        end
        $display("test registers done");

        // Out1,2 slot 0; out3 slot 1; out4 slot 2; out10..12 slot 11; out5 unused code
        wr(`A_DRV, 8'h15);
        wr(8'h5E, 8'h11);
        wr(8'h5F, 8'h32);
        wr(8'h60, 8'h0D);
        wr(8'h62, 8'hC0);
        wr(8'h63, 8'hCC);
        wr(8'h56, 8'h01);
        wr(8'h57, 8'h32);
        wr(8'h58, 8'h0D);
        wr(8'h5A, 8'hC0);
        wr(8'h72, 8'h01);
        arm();
        @(posedge core_clk_i);
        ext_en <= 1'b1;
        wait_pg();
        chk("outputs on", on, 12'hE0F);
        chk("slot 0 prompt", t_on[0] - t0 >= 1 && t_on[0] - t0 <= 4, 1'b1);
        chk("slot 0 together", t_on[0] === t_on[1], 1'b1);
        chk("slot 11 together", t_on[9] === t_on[10] && t_on[10] === t_on[11], 1'b1);
        chk("ascending", t_on[0] < t_on[2] && t_on[2] < t_on[3] && t_on[3] < t_on[9], 1'b1);
        chk("slot 2 delay", t_on[3] - t_on[2] >= D1, 1'b1);
        chk("slot 12 monitor", t_pg > t_on[9] + LAG, 1'b1);
        rdc("status on", `A_STAT, 8'h07, 8'h02);
        arm();
        @(posedge core_clk_i);
        ext_en <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk("all off", on, 12'h000);
        chk("reset asserted", {rst_act, pgood}, 2'b10);
        chk("simultaneous", t_off[0] === t_off[11] && t_off[2] === t_off[9], 1'b1);
        $display("test power-up and simultaneous power-down done");

        wr(`A_REV, 8'h10);
        wr(8'h5A, 8'h00);
        wr(`A_SWEN, 8'h01);
        @(posedge core_clk_i);
        ext_en <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        #1;
        chk("held by software", on, 12'h000);
        arm();
        wr(`A_SWEN, 8'h00);
        wait_pg();
        chk("no slot 12 monitor", t_pg - t_on[9] < LAG, 1'b1);
        arm();
        wr(`A_SWEN, 8'h01);
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("reset asserted", {rst_act, pgood}, 2'b10);
        for (n = 0; n < 6000 && on !== 12'h000; n++) @(posedge core_clk_i);
        repeat (4) @(posedge core_clk_i);
        chk("reverse done", on, 12'h000);
        chk("slot 11 first", t_off[9] === t_off[11] && t_off[9] < t_off[3], 1'b1);
        chk("descending", t_off[3] < t_off[2] && t_off[2] < t_off[0], 1'b1);
        chk("slot 2 off delay", t_off[2] - t_off[3] >= D1, 1'b1);
        chk("slot 0 together", t_off[0] === t_off[1], 1'b1);
        @(posedge core_clk_i);
        ext_en <= 1'b0;
        wr(`A_SWEN, 8'h00);
        $display("test reverse power-down done");

        wr(`A_REV, 8'h00);
        fail <= 12'h004;
        arm();
        @(posedge core_clk_i);
        ext_en <= 1'b1;
        for (n = 0; n < 5000 && fault !== 1'b1; n++) @(posedge core_clk_i);
        #1;
        chk("fault", fault, 1'b1);
        chk("fault delay", t_flt - t_on[2] >= PUF - 2 && t_flt - t_on[2] <= PUF + 8, 1'b1);
        repeat (50) @(posedge core_clk_i);
        #1;
        chk("frozen", {on, pgood}, {12'h007, 1'b0});
        @(posedge core_clk_i);
        ext_en <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        #1;
        chk("fault power-down", on, 12'h000);
        $display("test fault done");
        print_verdict();
    end
endmodule // tb_top
